// [design/smrtc_top.sv]
`timescale 1ns/10ps
module smrtc_top #(
    parameter int unsigned SEC_CYCLES       = smrtc_pkg::SEC_CYCLES,
    parameter int unsigned WD_BASE_CYCLES   = smrtc_pkg::WD_BASE_CYCLES,
    parameter int unsigned RST_PULSE_CYCLES = smrtc_pkg::RST_PULSE_CYCLES
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic [18:0] address_lines,
    input  wire logic [7:0]  data_lines_in,
    output logic [7:0]       data_lines_out,
    output logic             data_lines_oe,
    input  wire logic        chip_en_n,
    input  wire logic        out_en_n,
    input  wire logic        wr_en_n,
    input  wire logic        watchdog_kick_input,
    input  wire logic        external_reset_input_n,
    input  wire logic        power_fail_in,
    input  wire logic        battery_low_in,
    output logic             reset_out_n,
    output logic             reset_out_oe,
    output logic             interrupt_freqtest_out_n,
    output logic             interrupt_freqtest_oe
);
    localparam int SW = $clog2(SEC_CYCLES);
    localparam int BW = $clog2(WD_BASE_CYCLES);
    localparam int RW = $clog2(RST_PULSE_CYCLES + 1);

    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    smrtc_pkg::smrtc_pins_t pins_raw;
    smrtc_pkg::smrtc_pins_t pins_s;

    assign pins_raw = {address_lines, data_lines_in, chip_en_n, out_en_n, wr_en_n,
                       watchdog_kick_input, external_reset_input_n, power_fail_in,
                       battery_low_in};

    smrtc_sync #(
        .W       ($bits(smrtc_pkg::smrtc_pins_t)),
        .RST_VAL (smrtc_pkg::PINS_RST)
    ) u_sync (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .d       (pins_raw),
        .q       (pins_s)
    );

    // ------------------------------------------------------------
    // Address decode: {hit, register index}
    // ------------------------------------------------------------
    function automatic logic [4:0] reg_decode(input logic [18:0] a);
        if (a == smrtc_pkg::ADDR_CENTURY) begin
            reg_decode = {1'h1, smrtc_pkg::IDX_CENTURY};
        end else if (a >= smrtc_pkg::ADDR_SEC) begin
            reg_decode = {1'h1, 4'(a - smrtc_pkg::ADDR_SEC)};
        end else if (a == smrtc_pkg::ADDR_CTRL) begin
            reg_decode = {1'h1, smrtc_pkg::IDX_CTRL};
        end else if (a == smrtc_pkg::ADDR_WDOG) begin
            reg_decode = {1'h1, smrtc_pkg::IDX_WDOG};
        end else if (a == smrtc_pkg::ADDR_FLAGS) begin
            reg_decode = {1'h1, smrtc_pkg::IDX_FLAGS};
        end else if (a >= smrtc_pkg::ADDR_ALM_SEC && a <= smrtc_pkg::ADDR_ALM_MONTH) begin
            reg_decode = {1'h1, smrtc_pkg::IDX_ALM_MONTH + 4'(smrtc_pkg::ADDR_ALM_MONTH - a)};
        end else begin
            reg_decode = 5'h00;
        end
    endfunction

    // ------------------------------------------------------------
    // Bus cycle tracking
    // ------------------------------------------------------------
    smrtc_pkg::smrtc_bus_state_t state_q;
    smrtc_pkg::smrtc_bus_state_t state_d;
    logic [18:0] waddr_q;
    logic [7:0]  wdata_q;
    logic        flag_rd_q;
    wire         rd_req    = !pins_s.ce_n && pins_s.we_n;
    wire         wr_req    = !pins_s.ce_n && !pins_s.we_n;
    wire         wr_commit = (state_q == smrtc_pkg::SMRTC_WRITE) && !wr_req;
    wire         wr_ok     = wr_commit && !pins_s.pwr_fail;
    wire [4:0]   rd_dec    = reg_decode(pins_s.addr);
    wire [4:0]   wr_dec    = reg_decode(waddr_q);
    wire         flag_clr  = flag_rd_q && !rd_req;

    always_comb begin
        case (state_q)
            smrtc_pkg::SMRTC_IDLE:  state_d = wr_req ? smrtc_pkg::SMRTC_WRITE
                                     : rd_req ? smrtc_pkg::SMRTC_READ : smrtc_pkg::SMRTC_IDLE;
            smrtc_pkg::SMRTC_READ:  state_d = wr_req ? smrtc_pkg::SMRTC_WRITE
                                     : rd_req ? smrtc_pkg::SMRTC_READ : smrtc_pkg::SMRTC_IDLE;
            smrtc_pkg::SMRTC_WRITE: state_d = wr_req ? smrtc_pkg::SMRTC_WRITE
                                     : smrtc_pkg::SMRTC_IDLE;
            default:                state_d = smrtc_pkg::SMRTC_IDLE;
        endcase
    end

    // Last address and data seen inside the strobe overlap are the ones kept
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q   <= smrtc_pkg::SMRTC_IDLE;
            waddr_q   <= 19'h00000;
            wdata_q   <= 8'h00;
            flag_rd_q <= 1'h0;
        end else begin
            state_q   <= state_d;
            flag_rd_q <= rd_req && (flag_rd_q || rd_dec == {1'h1, smrtc_pkg::IDX_FLAGS});
            if (wr_req) begin
                waddr_q <= pins_s.addr;
                wdata_q <= pins_s.data;
            end
        end
    end

    // ------------------------------------------------------------
    // Memory array
    // ------------------------------------------------------------
    logic [7:0] mem [0:(1 << smrtc_pkg::ADDR_W) - 1];

    always_ff @(posedge sys_clk) begin
        if (wr_ok && !wr_dec[4]) begin
            mem[waddr_q] <= wdata_q;
        end
    end

    // ------------------------------------------------------------
    // Second divider and time counters
    // ------------------------------------------------------------
    logic [SW-1:0]          sec_cnt_q;
    logic                   sec_tick_q;
    logic                   tick2_q;
    logic                   load_q;
    logic [7:0]             regs_q [smrtc_pkg::NREG];
    logic [63:0]            shadow_v;
    smrtc_pkg::smrtc_time_t cur;
    wire  [63:0]            cur_v  = cur;
    wire  [7:0]             ctrl   = regs_q[smrtc_pkg::IDX_CTRL];
    wire  [7:0]             wdog   = regs_q[smrtc_pkg::IDX_WDOG];
    wire  [7:0]             flags  = regs_q[smrtc_pkg::IDX_FLAGS];
    wire  [7:0]             alm_mo = regs_q[smrtc_pkg::IDX_ALM_MONTH];
    // Host freeze bits hold the readable copy still so multi-byte reads agree
    wire                    upd    = tick2_q && !load_q
                                     && !ctrl[smrtc_pkg::CTRL_WRITE_BIT]
                                     && !ctrl[smrtc_pkg::CTRL_READ_BIT];
    wire                    ctrl_wr = wr_ok && wr_dec == {1'h1, smrtc_pkg::IDX_CTRL};
    wire                    alarm_hit = tick2_q
                                && {1'h0, alm_mo[6:0]} == cur.month
                                && regs_q[smrtc_pkg::IDX_ALM_MONTH + 4'h1] == cur.date
                                && regs_q[smrtc_pkg::IDX_ALM_MONTH + 4'h2] == cur.hour
                                && regs_q[smrtc_pkg::IDX_ALM_MONTH + 4'h3] == cur.minute
                                && regs_q[smrtc_pkg::IDX_ALM_MONTH + 4'h4] == cur.second;

    // Calibration bits are stored only; the divider is not trimmed by them
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sec_cnt_q  <= '0;
            sec_tick_q <= 1'h0;
            tick2_q    <= 1'h0;
            load_q     <= 1'h0;
        end else begin
            sec_tick_q <= sec_cnt_q == SW'(SEC_CYCLES - 1);
            sec_cnt_q  <= (sec_cnt_q == SW'(SEC_CYCLES - 1)) ? '0 : sec_cnt_q + SW'(1);
            tick2_q    <= sec_tick_q;
            // Clearing the write bit transfers the host-set time to the counters
            load_q     <= ctrl_wr && ctrl[smrtc_pkg::CTRL_WRITE_BIT]
                          && !wdata_q[smrtc_pkg::CTRL_WRITE_BIT];
        end
    end

    smrtc_tcnt u_tcnt (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .tick     (sec_tick_q),
        .load     (load_q),
        .load_val (smrtc_pkg::smrtc_time_t'(shadow_v)),
        .cur_q    (cur)
    );

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic wd_expire;

    for (genvar i = 0; i < smrtc_pkg::NREG; i++) begin : g_reg
        if (i < 8) begin : g_time
            assign shadow_v[i*8 +: 8] = regs_q[i];
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    regs_q[i] <= smrtc_pkg::REG_RST[i*8 +: 8];
                end else if (wr_ok && wr_dec == {1'h1, 4'(i)}) begin
                    regs_q[i] <= wdata_q;
                end else if (upd) begin
                    regs_q[i] <= cur_v[i*8 +: 8];
                end
            end
        end else if (i == smrtc_pkg::IDX_FLAGS) begin : g_flags
            // Reading the flags byte clears the event bits; a new event wins
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    regs_q[i] <= smrtc_pkg::REG_RST[i*8 +: 8];
                end else begin
                    regs_q[i] <= '0;
                    regs_q[i][smrtc_pkg::FLAG_WD_BIT] <= wd_expire
                        || (flags[smrtc_pkg::FLAG_WD_BIT] && !flag_clr);
                    regs_q[i][smrtc_pkg::FLAG_ALM_BIT] <= alarm_hit
                        || (flags[smrtc_pkg::FLAG_ALM_BIT] && !flag_clr);
                    regs_q[i][smrtc_pkg::FLAG_BAT_BIT] <= pins_s.bat_low;
                end
            end
        end else begin : g_plain
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    regs_q[i] <= smrtc_pkg::REG_RST[i*8 +: 8];
                end else if (wr_ok && wr_dec == {1'h1, 4'(i)}) begin
                    regs_q[i] <= wdata_q;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------
    logic [BW-1:0] base_cnt_q;
    logic [5:0]    pre_q;
    logic [4:0]    wd_cnt_q;
    logic          kick_prev_q;
    logic [RW-1:0] rst_cnt_q;
    wire  [4:0]    wd_mult   = wdog[smrtc_pkg::WD_MULT_MSB:smrtc_pkg::WD_MULT_LSB];
    wire  [1:0]    wd_res    = wdog[smrtc_pkg::WD_RES_MSB:0];
    wire           base_tick = base_cnt_q == BW'(WD_BASE_CYCLES - 1);
    wire           pre_last  = pre_q == ((6'h01 << {wd_res, 1'h0}) - 6'h01);
    wire           unit_tick = base_tick && pre_last;
    // Any kick-pin transition or a write to the setting restarts the period
    wire           wd_restart = (pins_s.kick != kick_prev_q) || wd_mult == 5'h00
                                || (wr_ok && wr_dec == {1'h1, smrtc_pkg::IDX_WDOG});
    assign wd_expire = !wd_restart && unit_tick && (wd_cnt_q + 5'h01 == wd_mult);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            base_cnt_q  <= '0;
            pre_q       <= 6'h00;
            wd_cnt_q    <= 5'h00;
            kick_prev_q <= 1'h0;
        end else begin
            kick_prev_q <= pins_s.kick;
            if (wd_restart) begin
                base_cnt_q <= '0;
                pre_q      <= 6'h00;
                wd_cnt_q   <= 5'h00;
            end else begin
                base_cnt_q <= base_tick ? '0 : base_cnt_q + BW'(1);
                if (base_tick) begin
                    pre_q <= pre_last ? 6'h00 : pre_q + 6'h01;
                end
                if (unit_tick) begin
                    wd_cnt_q <= wd_expire ? 5'h00 : wd_cnt_q + 5'h01;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Pin outputs
    // ------------------------------------------------------------
    logic [7:0] data_q;
    logic       data_oe_q;
    logic       rst_oe_q;
    logic       irq_oe_q;
    logic       drive_low_q;
    wire  [7:0] rd_mux = rd_dec[4] ? regs_q[rd_dec[3:0]] : mem[pins_s.addr];

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_cnt_q   <= '0;
            data_q      <= 8'h00;
            data_oe_q   <= 1'h0;
            rst_oe_q    <= 1'h0;
            irq_oe_q    <= 1'h0;
            drive_low_q <= 1'h0;
        end else begin
            if (wd_expire && wdog[smrtc_pkg::WD_STEER_BIT]) begin
                rst_cnt_q <= RW'(RST_PULSE_CYCLES);
            end else if (rst_cnt_q != '0) begin
                rst_cnt_q <= rst_cnt_q - RW'(1);
            end
            data_q    <= rd_mux;
            data_oe_q <= !pins_s.ce_n && !pins_s.oe_n && pins_s.we_n;
            rst_oe_q  <= !pins_s.ext_rst_n || rst_cnt_q != '0;
            irq_oe_q  <= (flags[smrtc_pkg::FLAG_WD_BIT] && !wdog[smrtc_pkg::WD_STEER_BIT])
                         || (flags[smrtc_pkg::FLAG_ALM_BIT] && alm_mo[smrtc_pkg::ALM_EN_BIT]);
        end
    end

    assign data_lines_out           = data_q;
    assign data_lines_oe            = data_oe_q;
    assign reset_out_n              = drive_low_q;
    assign reset_out_oe             = rst_oe_q;
    assign interrupt_freqtest_out_n = drive_low_q;
    assign interrupt_freqtest_oe    = irq_oe_q;
endmodule

// [design/smrtc_pkg.sv]
// Operation
// - Time bytes are BCD, hours on 24-hour scale
// - Date rolls over by month length, leap year
// - Readable time bytes are separate from the counters
// - Counters are copied into time bytes every second
// - Clock bytes use ordinary memory bus cycles
// - Control byte gates time access, holds calibration
// - A byte holds the watchdog configuration
// - Watchdog expiry: reset or interrupt by steer bit
// - Alarm fires on month, date, hour, minute, second
// - Century has its own byte, updated with clock
// - Flags byte reports watchdog, alarm and battery
// - Supply out of tolerance blocks every write
// - Byte memory, nineteen address lines, eight data lines
// - Data driven only while chip select, output enable low
// - Write spans overlap of write strobe, chip select
package smrtc_pkg;

    // ------------------------------------------------------------
    // Address map
    // ------------------------------------------------------------
    localparam int          ADDR_W         = 19;
    localparam int          DATA_W         = 8;
    localparam int          NREG           = 16;
    localparam logic [18:0] ADDR_SEC       = 19'h7FFF9;
    localparam logic [18:0] ADDR_ALM_MONTH = 19'h7FFF6;
    localparam logic [18:0] ADDR_ALM_SEC   = 19'h7FFF2;
    localparam logic [18:0] ADDR_CENTURY   = 19'h7FFF1;
    localparam logic [18:0] ADDR_FLAGS     = 19'h7FFF0;
    localparam logic [18:0] ADDR_CTRL      = 19'h07FF8;
    localparam logic [18:0] ADDR_WDOG      = 19'h07FF7;

    // Register file index: 0..7 time bytes (second up to century)
    localparam logic [3:0]  IDX_SEC        = 4'h0;
    localparam logic [3:0]  IDX_CENTURY    = 4'h7;
    localparam logic [3:0]  IDX_CTRL       = 4'h8;
    localparam logic [3:0]  IDX_WDOG       = 4'h9;
    localparam logic [3:0]  IDX_FLAGS      = 4'hA;
    localparam logic [3:0]  IDX_ALM_MONTH  = 4'hB;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int          CTRL_WRITE_BIT = 7;
    localparam int          CTRL_READ_BIT  = 6;
    localparam int          WD_STEER_BIT   = 7;
    localparam int          WD_MULT_MSB    = 6;
    localparam int          WD_MULT_LSB    = 2;
    localparam int          WD_RES_MSB     = 1;
    localparam int          FLAG_WD_BIT    = 7;
    localparam int          FLAG_ALM_BIT   = 6;
    localparam int          FLAG_BAT_BIT   = 4;
    localparam int          ALM_EN_BIT     = 7;

    // Reset values, index 15 down to index 0
    localparam logic [127:0] REG_RST = 128'h0000_0001_0100_0000_2000_0101_0100_0000;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS     = 10;
    localparam int SEC_TIME_NS       = 1_000_000_000;
    localparam int SEC_CYCLES        = SEC_TIME_NS / CLK_PERIOD_NS;
    localparam int WD_BASE_TIME_NS   = 62_500_000;
    localparam int WD_BASE_CYCLES    = WD_BASE_TIME_NS / CLK_PERIOD_NS;
    localparam int RST_PULSE_TIME_NS = 40_000_000;
    localparam int RST_PULSE_CYCLES  = RST_PULSE_TIME_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] century;
        logic [7:0] year;
        logic [7:0] month;
        logic [7:0] date;
        logic [7:0] day;
        logic [7:0] hour;
        logic [7:0] minute;
        logic [7:0] second;
    } smrtc_time_t;

    typedef struct packed {
        logic [18:0] addr;
        logic [7:0]  data;
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
        logic        kick;
        logic        ext_rst_n;
        logic        pwr_fail;
        logic        bat_low;
    } smrtc_pins_t;

    localparam smrtc_time_t TIME_RST = REG_RST[63:0];
    localparam smrtc_pins_t PINS_RST = '{addr: 19'h00000, data: 8'h00, ce_n: 1'h1,
                                         oe_n: 1'h1, we_n: 1'h1, kick: 1'h0,
                                         ext_rst_n: 1'h1, pwr_fail: 1'h0, bat_low: 1'h0};

    typedef enum logic [2:0] {
        SMRTC_IDLE  = 3'b001,
        SMRTC_READ  = 3'b010,
        SMRTC_WRITE = 3'b100
    } smrtc_bus_state_t;

endpackage

// [design/smrtc_sync.sv]
`timescale 1ns/10ps
module smrtc_sync #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic [W-1:0]      q
);
    logic [W-1:0] meta_q;

    // ------------------------------------------------------------
    // Two-stage synchroniser; first stage feeds only the second
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= RST_VAL;
            q      <= RST_VAL;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule

// [design/smrtc_tcnt.sv]
`timescale 1ns/10ps
module smrtc_tcnt (
    input  wire logic                   sys_clk,
    input  wire logic                   rst_n,
    input  wire logic                   tick,
    input  wire logic                   load,
    input  wire smrtc_pkg::smrtc_time_t load_val,
    output var smrtc_pkg::smrtc_time_t  cur_q
);
    smrtc_pkg::smrtc_time_t nxt;

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
    endfunction

    // Year 00 counts as leap; century rule is not applied
    function automatic logic [7:0] month_last(input logic [7:0] m, input logic [7:0] y);
        logic leap;
        leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                    : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
        case (m)
            8'h02:                      month_last = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: month_last = 8'h30;
            default:                    month_last = 8'h31;
        endcase
    endfunction

    // ------------------------------------------------------------
    // BCD carry chain
    // ------------------------------------------------------------
    always_comb begin
        nxt = cur_q;
        if (cur_q.second != 8'h59) begin
            nxt.second = bcd_inc(cur_q.second);
        end else begin
            nxt.second = 8'h00;
            if (cur_q.minute != 8'h59) begin
                nxt.minute = bcd_inc(cur_q.minute);
            end else begin
                nxt.minute = 8'h00;
                if (cur_q.hour != 8'h23) begin
                    nxt.hour = bcd_inc(cur_q.hour);
                end else begin
                    nxt.hour = 8'h00;
                    nxt.day  = (cur_q.day == 8'h07) ? 8'h01 : bcd_inc(cur_q.day);
                    if (cur_q.date != month_last(cur_q.month, cur_q.year)) begin
                        nxt.date = bcd_inc(cur_q.date);
                    end else begin
                        nxt.date = 8'h01;
                        if (cur_q.month != 8'h12) begin
                            nxt.month = bcd_inc(cur_q.month);
                        end else begin
                            nxt.month = 8'h01;
                            if (cur_q.year != 8'h99) begin
                                nxt.year = bcd_inc(cur_q.year);
                            end else begin
                                nxt.year    = 8'h00;
                                nxt.century = (cur_q.century == 8'h99) ? 8'h00
                                                : bcd_inc(cur_q.century);
                            end
                        end
                    end
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_q <= smrtc_pkg::TIME_RST;
        end else if (load) begin
            cur_q <= load_val;
        end else if (tick) begin
            cur_q <= nxt;
        end
    end
endmodule

// [verif/smrtc_host.sv]
`timescale 1ns/10ps
module smrtc_host (
    input  wire logic        sys_clk,
    input  wire logic [7:0]  data_lines_out,
    input  wire logic        data_lines_oe,
    output logic [18:0]      address_lines,
    output logic [7:0]       data_lines_in,
    output logic             chip_en_n,
    output logic             out_en_n,
    output logic             wr_en_n
);
    initial begin
        address_lines = 19'h00000;
        data_lines_in = 8'h00;
        {chip_en_n, out_en_n, wr_en_n} = 3'h7;
    end
    task automatic wr(input logic [18:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        address_lines <= a;
        data_lines_in <= d;
        {chip_en_n, wr_en_n} <= 2'h0;
        repeat (4) @(posedge sys_clk);
        {chip_en_n, wr_en_n} <= 2'h3;
        repeat (2) @(posedge sys_clk);
        // Released lines show the inverse so a stale byte cannot pass
        data_lines_in <= ~d;
        repeat (3) @(posedge sys_clk);
    endtask
    task automatic rd(input logic [18:0] a, output logic [7:0] q, output logic ok);
        @(posedge sys_clk);
        address_lines <= a;
        {chip_en_n, out_en_n} <= 2'h0;
        ok = 1'h0;
        for (int i = 0; i < 8 && !ok; i++) begin
            @(posedge sys_clk);
            ok = (data_lines_oe === 1'h1);
        end
        q = data_lines_out;
        {chip_en_n, out_en_n} <= 2'h3;
        repeat (4) @(posedge sys_clk);
    endtask
endmodule

// [verif/smrtc_sva.sv]
`timescale 1ns/10ps
module smrtc_sva #(
    parameter int unsigned RST_PULSE_CYCLES = smrtc_pkg::RST_PULSE_CYCLES
) (
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic [18:0] address_lines,
    input wire logic [7:0]  data_lines_out,
    input wire logic        data_lines_oe,
    input wire logic        chip_en_n,
    input wire logic        out_en_n,
    input wire logic        wr_en_n,
    input wire logic        reset_out_n,
    input wire logic        reset_out_oe,
    input wire logic        interrupt_freqtest_out_n
);
    wire         rd_cond = !chip_en_n && !out_en_n && wr_en_n;
    wire         wr_cond = !chip_en_n && !wr_en_n;
    logic [31:0] hi_cnt_q;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) hi_cnt_q <= 32'h0;
        else hi_cnt_q <= reset_out_oe ? hi_cnt_q + 32'h1 : 32'h0;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_read_held;
        rd_cond [*2];
    endsequence
    a_oe_needs_read: assert property (data_lines_oe |-> $past(rd_cond, 3))
        else $error("data lines driven outside a read");
    a_read_gives_oe: assert property (s_read_held |-> ##3 data_lines_oe)
        else $error("read not answered");
    a_write_no_drive: assert property ($past(wr_cond, 3) |-> !data_lines_oe)
        else $error("data lines driven during a write");
    a_data_steady: assert property (data_lines_oe && $past(data_lines_oe)
        && $past(address_lines, 3) == $past(address_lines, 4)
        && $past(address_lines, 3) < 19'h7FFF0 |-> $stable(data_lines_out))
        else $error("read data moved on a steady address");
    a_rst_pin_low: assert property (reset_out_oe |-> !reset_out_n)
        else $error("reset pin value not low");
    a_irq_pin_low: assert property (!interrupt_freqtest_out_n)
        else $error("interrupt pin value not low");
    a_pulse_max: assert property (hi_cnt_q <= RST_PULSE_CYCLES)
        else $error("reset pulse too long");
    a_pulse_exact: assert property ($fell(reset_out_oe) |-> hi_cnt_q == RST_PULSE_CYCLES)
        else $error("reset pulse length wrong");
endmodule
bind smrtc_top smrtc_sva #(.RST_PULSE_CYCLES(RST_PULSE_CYCLES)) u_sva (.*);

// [verif/smrtc_top_tb.sv]
`timescale 1ns/10ps
module smrtc_top_tb;
    logic        sys_clk        = 1'h0;
    logic        rst_n          = 1'h0;
    logic        power_fail_in  = 1'h0;
    logic        battery_low_in = 1'h1;
    logic [18:0] address_lines;
    logic [7:0]  data_lines_in, data_lines_out, rd_q;
    logic        chip_en_n, out_en_n, wr_en_n, data_lines_oe, ok;
    logic        reset_out_n, reset_out_oe, irq_n, irq_oe;
    int          failures, cmp_count;
    // Short counts keep the run small; expectations follow these values
    smrtc_top #(.SEC_CYCLES(100), .WD_BASE_CYCLES(4), .RST_PULSE_CYCLES(8)) dut (.*,
        .watchdog_kick_input(1'h0), .external_reset_input_n(1'h1),
        .interrupt_freqtest_out_n(irq_n), .interrupt_freqtest_oe(irq_oe));
    smrtc_host host (.*);
    initial forever #5 sys_clk = ~sys_clk;
    task automatic test_done();
        if (failures == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd_chk(input logic [18:0] a, input logic [7:0] exp);
        host.rd(a, rd_q, ok);
        if (ok !== 1'h1) begin
            failures++;
            test_done();
        end else check(rd_q, exp);
    endtask
    task automatic wait_pin(input logic rst_pin);
        cmp_count++;
        for (int i = 0; i < 40; i++) begin
            @(posedge sys_clk);
            if ((rst_pin ? reset_out_oe : irq_oe) === 1'h1) return;
        end
        failures++;
        test_done();
    endtask
    task automatic t_reset();
        rd_chk(19'h7FFF1, 8'h20);
        rd_chk(19'h07FF7, 8'h00);
        rd_chk(19'h07FF8, 8'h00);
    endtask
    task automatic t_mem();
        host.wr(19'h7FFEF, 8'hA5);
        rd_chk(19'h7FFEF, 8'hA5);
        power_fail_in <= 1'h1;
        host.wr(19'h7FFEF, 8'h5A);
        rd_chk(19'h7FFEF, 8'hA5);
        power_fail_in <= 1'h0;
        host.wr(19'h07FF8, 8'h2A);
        rd_chk(19'h07FF8, 8'h2A);
    endtask
    task automatic t_clock();
        logic [7:0] tv [6] = '{8'h59, 8'h59, 8'h23, 8'h28, 8'h02, 8'h01};
        host.wr(19'h07FF8, 8'h80);
        for (int i = 0; i < 6; i++) host.wr(19'h7FFF9 + 19'(i) + 19'(i > 2), tv[i]);
        host.wr(19'h7FFF6, 8'h83);
        host.wr(19'h07FF8, 8'h00);
        repeat (60) @(posedge sys_clk);
        rd_chk(19'h7FFFD, 8'h01);
        rd_chk(19'h7FFFE, 8'h03);
        rd_chk(19'h7FFFB, 8'h00);
        rd_chk(19'h7FFF9, 8'h00);
        rd_chk(19'h7FFF0, 8'h50);
    endtask
    task automatic t_wdog();
        host.wr(19'h07FF7, 8'h04);
        wait_pin(1'h0);
        host.rd(19'h7FFF0, rd_q, ok);
        check(rd_q & 8'h90, 8'h90);
        host.wr(19'h07FF7, 8'h90);
        wait_pin(1'h1);
        rd_chk(19'h07FF7, 8'h90);
        host.wr(19'h07FF7, 8'h00);
    endtask
    initial begin
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'h1;
        t_reset();
        t_mem();
        t_clock();
        t_wdog();
        test_done();
    end
endmodule
